/* File: include/bcx_params.svh */
`ifndef BCX_PARAMS_SVH
`define BCX_PARAMS_SVH
`define BCX_PC_W        16
`define BCX_PC_RST      16'h0000
`define BCX_PC_ONE      16'h0001
`define BCX_SKIP1_WORDS 16'h0002
`define BCX_SKIP2_WORDS 16'h0003
`define BCX_OP_INDIRECT_CALL    16'h9509
`define BCX_OP_RET      16'h9508
`define BCX_OP_INTERRUPT_EXIT     16'h9518
`define BCX_MSK_RR      16'hFC00
`define BCX_OP_COMPARE_SKIP_EQUAL     16'h1000
`define BCX_OP_CP       16'h1400
`define BCX_OP_CPC      16'h0400
`define BCX_MSK_CPI     16'hF000
`define BCX_OP_CPI      16'h3000
`define BCX_MSK_SBR     16'hFE08
`define BCX_OP_SKIP_REG_BIT_CLEAR     16'hFC00
`define BCX_OP_SKIP_REG_BIT_SET     16'hFE00
`define BCX_MSK_SBI     16'hFF00
`define BCX_OP_SKIP_IO_BIT_CLEAR     16'h9900
`define BCX_OP_SKIP_IO_BIT_SET     16'h9B00
`define BCX_MSK_BRB     16'hFC00
`define BCX_OP_BRANCH_STATUS_SET     16'hF000
`define BCX_OP_BRANCH_STATUS_CLEAR     16'hF400
`define BCX_F_BIT_HI    2
`define BCX_F_BIT_LO    0
`define BCX_F_K_HI      9
`define BCX_F_K_LO      3
`define BCX_F_KH_HI     11
`define BCX_F_KH_LO     8
`define BCX_F_KL_HI     3
`define BCX_F_KL_LO     0
`define BCX_SR_C        0
`define BCX_SR_Z        1
`define BCX_SR_N        2
`define BCX_SR_V        3
`define BCX_SR_S        4
`define BCX_SR_H        5
`define BCX_SR_T        6
`define BCX_SR_I        7
`define BCX_SR_RST      8'h00
`define BCX_STALL_NONE  2'h0
`define BCX_STALL_ONE   2'h1
`define BCX_STALL_TWO   2'h2
`define BCX_STALL_INDIRECT_CALL 2'h2
`define BCX_STALL_RET   2'h3
`define BCX_ADDR_CTRL   8'h00
`define BCX_ADDR_PC     8'h04
`define BCX_ADDR_STATUS_REGISTER   8'h08
`define BCX_ADDR_STAT   8'h0C
`define BCX_CTRL_EN     0
`define BCX_CTRL_RST    1'b1
`define BCX_STAT_BUSY   0
`define BCX_STAT_UNH    1
`define BCX_STAT_TAKEN  2
`endif

/* File: include/bcx_pkg.sv */
package bcx_pkg;
  typedef enum logic [1:0] {
    BCX_ST_IDLE  = 2'b01,
    BCX_ST_STALL = 2'b10
  } bcx_state_e;
endpackage

/* File: logic/bcx_exec.sv */
`timescale 1ns/10ps
`include "bcx_params.svh"
module bcx_exec (
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 hsel_in,
  input  wire logic [31:0]          haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  input  wire logic                 instr_valid_in,
  input  wire logic [15:0]          instr_word_in,
  input  wire logic                 next_two_word_in,
  input  wire logic [7:0]           rd_data_in,
  input  wire logic [7:0]           rr_data_in,
  input  wire logic [7:0]           io_data_in,
  input  wire logic [`BCX_PC_W-1:0] z_ptr_in,
  input  wire logic [`BCX_PC_W-1:0] stack_top_in,
  output logic                      instr_ready_out,
  output logic [`BCX_PC_W-1:0]      pc_out,
  output logic [7:0]                status_register_out,
  output logic                      stack_push_out,
  output logic                      stack_pop_out,
  output logic [`BCX_PC_W-1:0]      stack_data_out,
  output logic                      unhandled_out
);
  bcx_pkg::bcx_state_e state_reg;
  logic [1:0]           stall_reg;
  logic                 ready_reg;
  logic [`BCX_PC_W-1:0] pc_reg;
  logic [7:0]           status_register_reg;
  logic                 ctrl_en_reg;
  logic                 unh_flag_reg;
  logic                 taken_reg;
  logic                 wr_pend_reg;
  logic [7:0]           wr_addr_reg;
  logic                 rd_pend_reg;
  logic [7:0]           rd_addr_reg;
  logic                 take;
  logic                 addr_ok;
  logic                 bus_wr;
  logic [`BCX_PC_W-1:0] pc_next;
  logic [7:0]           status_register_next;
  logic [1:0]           stall_next;
  logic                 push_c;
  logic                 pop_c;
  logic                 taken_c;
  logic                 unh_c;
  logic [`BCX_PC_W-1:0] pc_inc;
  logic [`BCX_PC_W-1:0] pc_skip;
  logic [`BCX_PC_W-1:0] pc_branch;
  logic [`BCX_PC_W-1:0] k_ext;
  logic [6:0]           k_fld;
  logic [2:0]           bsel;
  logic [7:0]           opb;
  logic                 cin;
  logic [7:0]           diff;
  logic                 is_cmp;
  logic                 skip_c;

  // an instruction is taken only while the unit says ready
  assign take    = instr_valid_in & ready_reg;
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;
  assign bus_wr  = wr_pend_reg;

  // shared operand pieces
  assign bsel    = instr_word_in[`BCX_F_BIT_HI:`BCX_F_BIT_LO];
  assign k_fld   = instr_word_in[`BCX_F_K_HI:`BCX_F_K_LO];
  assign k_ext   = {{(`BCX_PC_W-7){k_fld[6]}}, k_fld};
  assign pc_inc  = pc_reg + `BCX_PC_ONE;
  // skip over one or two words
  assign pc_skip = next_two_word_in ? pc_reg + `BCX_SKIP2_WORDS
                                    : pc_reg + `BCX_SKIP1_WORDS;
  assign pc_branch = pc_reg + k_ext + `BCX_PC_ONE;

  // compare operand select; difference is never written back
  always_comb begin
    opb = rr_data_in;
    cin = 1'b0;
    if ((instr_word_in & `BCX_MSK_CPI) == `BCX_OP_CPI) begin
      opb = {instr_word_in[`BCX_F_KH_HI:`BCX_F_KH_LO],
             instr_word_in[`BCX_F_KL_HI:`BCX_F_KL_LO]};
    end
    if ((instr_word_in & `BCX_MSK_RR) == `BCX_OP_CPC) begin
      cin = status_register_reg[`BCX_SR_C];
    end
  end
  assign diff = rd_data_in - opb - {7'h00, cin};

  // instruction decode and next program counter
  always_comb begin
    pc_next    = pc_inc;
    status_register_next  = status_register_reg;
    stall_next = `BCX_STALL_NONE;
    push_c     = 1'b0;
    pop_c      = 1'b0;
    taken_c    = 1'b0;
    unh_c      = 1'b0;
    is_cmp     = 1'b0;
    skip_c     = 1'b0;
    if (instr_word_in == `BCX_OP_INDIRECT_CALL) begin
      push_c     = 1'b1;
      pc_next    = z_ptr_in;
      stall_next = `BCX_STALL_INDIRECT_CALL;
    end else if (instr_word_in == `BCX_OP_RET) begin
      pop_c      = 1'b1;
      pc_next    = stack_top_in;
      stall_next = `BCX_STALL_RET;
    end else if (instr_word_in == `BCX_OP_INTERRUPT_EXIT) begin
      pop_c      = 1'b1;
      pc_next    = stack_top_in;
      stall_next = `BCX_STALL_RET;
      status_register_next[`BCX_SR_I] = 1'b1;
    end else if ((instr_word_in & `BCX_MSK_RR) == `BCX_OP_COMPARE_SKIP_EQUAL) begin
      skip_c = (rd_data_in == rr_data_in);
    end else if (((instr_word_in & `BCX_MSK_RR) == `BCX_OP_CP) ||
                 ((instr_word_in & `BCX_MSK_RR) == `BCX_OP_CPC) ||
                 ((instr_word_in & `BCX_MSK_CPI) == `BCX_OP_CPI)) begin
      is_cmp = 1'b1;
    end else if ((instr_word_in & `BCX_MSK_SBR) == `BCX_OP_SKIP_REG_BIT_CLEAR) begin
      skip_c = ~rr_data_in[bsel];
    end else if ((instr_word_in & `BCX_MSK_SBR) == `BCX_OP_SKIP_REG_BIT_SET) begin
      skip_c = rr_data_in[bsel];
    end else if ((instr_word_in & `BCX_MSK_SBI) == `BCX_OP_SKIP_IO_BIT_CLEAR) begin
      skip_c = ~io_data_in[bsel];
    end else if ((instr_word_in & `BCX_MSK_SBI) == `BCX_OP_SKIP_IO_BIT_SET) begin
      skip_c = io_data_in[bsel];
    end else if ((instr_word_in & `BCX_MSK_BRB) == `BCX_OP_BRANCH_STATUS_SET) begin
      taken_c = status_register_reg[bsel];
    end else if ((instr_word_in & `BCX_MSK_BRB) == `BCX_OP_BRANCH_STATUS_CLEAR) begin
      taken_c = ~status_register_reg[bsel];
    end else begin
      unh_c = 1'b1; // left to the neighbouring units, step past it
    end
    if (skip_c) begin
      pc_next    = pc_skip;
      // two-word skip costs a cycle more
      stall_next = next_two_word_in ? `BCX_STALL_TWO : `BCX_STALL_ONE;
      taken_c    = 1'b1;
    end else if (taken_c) begin
      pc_next    = pc_branch;
      stall_next = `BCX_STALL_ONE;
    end
    if (is_cmp) begin
      status_register_next[`BCX_SR_H] = (~rd_data_in[3] & opb[3]) | (opb[3] & diff[3]) |
                             (diff[3] & ~rd_data_in[3]);
      status_register_next[`BCX_SR_V] = (rd_data_in[7] & ~opb[7] & ~diff[7]) |
                             (~rd_data_in[7] & opb[7] & diff[7]);
      status_register_next[`BCX_SR_N] = diff[7];
      status_register_next[`BCX_SR_C] = (~rd_data_in[7] & opb[7]) | (opb[7] & diff[7]) |
                             (diff[7] & ~rd_data_in[7]);
      status_register_next[`BCX_SR_S] = status_register_next[`BCX_SR_N] ^ status_register_next[`BCX_SR_V];
      // with carry the zero flag only survives, it is never set
      if (cin || ((instr_word_in & `BCX_MSK_RR) == `BCX_OP_CPC)) begin
        status_register_next[`BCX_SR_Z] = (diff == 8'h00) & status_register_reg[`BCX_SR_Z];
      end else begin
        status_register_next[`BCX_SR_Z] = (diff == 8'h00);
      end
    end
  end

  // stall sequencer; ready drops for the extra cycles of a multi-cycle op
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= bcx_pkg::BCX_ST_IDLE;
      stall_reg <= `BCX_STALL_NONE;
      ready_reg <= 1'b0;
    end else begin
      case (state_reg)
        bcx_pkg::BCX_ST_IDLE: begin
          if (take && (stall_next != `BCX_STALL_NONE)) begin
            state_reg <= bcx_pkg::BCX_ST_STALL;
            stall_reg <= stall_next;
            ready_reg <= 1'b0;
          end else begin
            ready_reg <= ctrl_en_reg;
          end
        end
        bcx_pkg::BCX_ST_STALL: begin
          stall_reg <= stall_reg - 2'h1;
          if (stall_reg == `BCX_STALL_ONE) begin
            state_reg <= bcx_pkg::BCX_ST_IDLE;
            ready_reg <= ctrl_en_reg;
          end
        end
        default: begin
          state_reg <= bcx_pkg::BCX_ST_IDLE;
          stall_reg <= `BCX_STALL_NONE;
          ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // program counter; a bus write wins over execution in the same cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pc_reg <= `BCX_PC_RST;
    end else if (bus_wr && (wr_addr_reg == `BCX_ADDR_PC)) begin
      pc_reg <= hwdata_in[`BCX_PC_W-1:0];
    end else if (take) begin
      pc_reg <= pc_next;
    end
  end

  // status register, same priority as the program counter
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_register_reg <= `BCX_SR_RST;
    end else if (bus_wr && (wr_addr_reg == `BCX_ADDR_STATUS_REGISTER)) begin
      status_register_reg <= hwdata_in[7:0];
    end else if (take) begin
      status_register_reg <= status_register_next;
    end
  end

  // stack strobes and return address, one-cycle pulses
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stack_push_out <= 1'b0;
      stack_pop_out  <= 1'b0;
      stack_data_out <= `BCX_PC_RST;
      unhandled_out  <= 1'b0;
    end else begin
      stack_push_out <= take & push_c;
      stack_pop_out  <= take & pop_c;
      unhandled_out  <= take & unh_c;
      if (take && push_c) begin
        stack_data_out <= pc_inc; // indirect_call is one word long
      end
    end
  end

  // control, sticky unhandled flag and last-taken status; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_en_reg  <= `BCX_CTRL_RST;
      unh_flag_reg <= 1'b0;
      taken_reg    <= 1'b0;
    end else begin
      if (bus_wr && (wr_addr_reg == `BCX_ADDR_CTRL)) begin
        ctrl_en_reg <= hwdata_in[`BCX_CTRL_EN];
      end
      unh_flag_reg <= (take & unh_c) | (unh_flag_reg &
                      ~(bus_wr && (wr_addr_reg == `BCX_ADDR_STAT) &&
                        hwdata_in[`BCX_STAT_UNH]));
      if (take) begin
        taken_reg <= taken_c;
      end
    end
  end

  // ahb address phase capture; reads take one wait state so the
  // mux sees any write that finished in the preceding data phase
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_in;
      rd_pend_reg <= addr_ok & ~hwrite_in;
      if (addr_ok) begin
        wr_addr_reg <= haddr_in[7:0];
        rd_addr_reg <= haddr_in[7:0];
      end
    end
  end

  // read data and ready; unmapped offsets read zero, always OKAY
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
      if (addr_ok && !hwrite_in) begin
        hreadyout_out <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout_out <= 1'b1;
        case (rd_addr_reg)
          `BCX_ADDR_CTRL: hrdata_out <= {31'h0000_0000, ctrl_en_reg};
          `BCX_ADDR_PC:   hrdata_out <= {16'h0000, pc_reg};
          `BCX_ADDR_STATUS_REGISTER: hrdata_out <= {24'h00_0000, status_register_reg};
          `BCX_ADDR_STAT: hrdata_out <= {29'h0000_0000, taken_reg,
                                         unh_flag_reg, ~ready_reg};
          default:        hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // core side mirrors
  assign instr_ready_out = ready_reg;
  assign pc_out          = pc_reg;
  assign status_register_out        = status_register_reg;
endmodule

/* File: tb/bcx_exec_checker.sv */
`timescale 1ns/10ps
`include "bcx_params.svh"
module bcx_exec_checker (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic        next_two_word_in,
  input wire logic [7:0]  rd_data_in,
  input wire logic [7:0]  rr_data_in,
  input wire logic [7:0]  io_data_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [15:0] stack_top_in,
  input wire logic        instr_ready_out,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  status_register_out,
  input wire logic        stack_push_out,
  input wire logic        stack_pop_out,
  input wire logic [15:0] stack_data_out,
  input wire logic        unhandled_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic        tk, br, go, cs, rb, ib, sk, hit;
  logic [15:0] w, bt, st;
  // decode of the word taken this cycle; bit9/bit10 pick the sense
  assign w   = instr_word_in;
  assign tk  = instr_valid_in & instr_ready_out;
  assign br  = ((w | 16'h0400) & `BCX_MSK_BRB) == `BCX_OP_BRANCH_STATUS_CLEAR;
  assign go  = status_register_out[w[2:0]] ^ w[10];
  assign cs  = (w & `BCX_MSK_RR) == `BCX_OP_COMPARE_SKIP_EQUAL;
  assign rb  = ((w | 16'h0200) & `BCX_MSK_SBR) == `BCX_OP_SKIP_REG_BIT_SET;
  assign ib  = ((w | 16'h0200) & `BCX_MSK_SBI) == `BCX_OP_SKIP_IO_BIT_SET;
  assign sk  = cs | rb | ib;
  assign hit = (cs & (rd_data_in == rr_data_in)) | (rb & (rr_data_in[w[2:0]] == w[9]))
             | (ib & (io_data_in[w[2:0]] == w[9]));
  assign bt  = pc_out + {{9{w[9]}}, w[9:3]} + 16'h0001;
  assign st  = pc_out + (next_two_word_in ? `BCX_SKIP2_WORDS : `BCX_SKIP1_WORDS);
  AST_INDIRECT_CALL_JUMP: assert property (tk && w == `BCX_OP_INDIRECT_CALL |=> pc_out == $past(z_ptr_in)
    && stack_push_out && stack_data_out == $past(pc_out) + 16'h0001) else $error("call bad");
  AST_INDIRECT_CALL_STALL: assert property (tk && w == `BCX_OP_INDIRECT_CALL |=>
    !instr_ready_out [*2] ##1 instr_ready_out) else $error("call length bad");
  AST_RET_POP: assert property (tk && (w == `BCX_OP_RET || w == `BCX_OP_INTERRUPT_EXIT) |=>
    (pc_out == $past(stack_top_in) && stack_pop_out && !instr_ready_out) ##1
    !instr_ready_out [*2] ##1 instr_ready_out) else $error("return bad");
  AST_INTERRUPT_EXIT_IE: assert property (tk && w == `BCX_OP_INTERRUPT_EXIT |=> status_register_out[`BCX_SR_I])
    else $error("irq enable not set");
  AST_FLAGS_HELD: assert property (tk && (br || sk || w == `BCX_OP_INDIRECT_CALL) |=>
    $stable(status_register_out)) else $error("flags changed");
  AST_BR_TAKEN: assert property (tk && br && go |=> pc_out == $past(bt)
    && !instr_ready_out ##1 instr_ready_out) else $error("branch taken bad");
  AST_BR_NOT: assert property (tk && br && !go |=> pc_out == $past(pc_out) + 16'h0001
    && instr_ready_out) else $error("branch not taken bad");
  AST_SKIP_HIT: assert property (tk && hit |=> pc_out == $past(st) && !instr_ready_out
    ##1 instr_ready_out != $past(next_two_word_in, 2)) else $error("skip bad");
  AST_SKIP_MISS: assert property (tk && sk && !hit |=> pc_out == $past(pc_out) + 16'h0001)
    else $error("skip miss bad");
  AST_CP_ZC: assert property (tk && (w & `BCX_MSK_RR) == `BCX_OP_CP |=>
    status_register_out[`BCX_SR_Z] == ($past(rd_data_in) == $past(rr_data_in)) &&
    status_register_out[`BCX_SR_C] == ($past(rd_data_in) < $past(rr_data_in))) else $error("cp flags bad");
  // foreign opcode pulses and steps by one
  AST_UNH_STEP: assert property (tk && w == 16'h0000 |=> unhandled_out
    && pc_out == $past(pc_out) + 16'h0001) else $error("unhandled step bad");
  COV_BR: cover property (tk && br && go);
  COV_SKIP2: cover property (tk && hit && next_two_word_in);
  COV_INTERRUPT_EXIT: cover property (tk && w == `BCX_OP_INTERRUPT_EXIT);
endmodule
bind bcx_exec bcx_exec_checker u_bcx_exec_checker (.*);

/* File: tb/bcx_core_model.sv */
`timescale 1ns/10ps
module bcx_core_model #(
  parameter logic [15:0] Z_VALUE = 16'h0123
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        stack_push_in,
  input  wire logic        stack_pop_in,
  input  wire logic [15:0] stack_data_in,
  output logic      [15:0] z_ptr_out,
  output logic      [15:0] stack_top_out
);
  logic [15:0] mem_reg [8];
  logic [2:0]  sp_reg;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sp_reg <= 3'h0;
    end else if (stack_push_in) begin
      mem_reg[sp_reg] <= stack_data_in;
      sp_reg          <= sp_reg + 3'h1;
    end else if (stack_pop_in) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end
  // empty stack shows garbage, never a stale return address
  assign stack_top_out = (sp_reg == 3'h0) ? ~mem_reg[0] : mem_reg[sp_reg - 3'h1];
  assign z_ptr_out     = Z_VALUE;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
`include "bcx_params.svh"
module tb;
  localparam logic [15:0] Z_VAL = 16'h0123;
  logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic        instr_valid_in = 1'b0, next_two_word_in = 1'b0, took = 1'b0;
  logic        hreadyout_out, hresp_out, instr_ready_out, stack_push_out, stack_pop_out;
  logic        unhandled_out, t;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rdv, r;
  logic [15:0] instr_word_in = 16'h0, z_ptr_in, stack_top_in, pc_out, stack_data_out;
  logic [15:0] pc_e, w, k, ra;
  logic [7:0]  rd_data_in = 8'h0, rr_data_in = 8'h0, io_data_in = 8'h0, status_register_out, sr_e, d, e;
  logic [23:0] exp_q[$];
  logic [15:0] sop [5] = '{`BCX_OP_COMPARE_SKIP_EQUAL, `BCX_OP_SKIP_REG_BIT_CLEAR, `BCX_OP_SKIP_REG_BIT_SET, `BCX_OP_SKIP_IO_BIT_CLEAR, `BCX_OP_SKIP_IO_BIT_SET};
  int          err_count = 0, comparisons = 0, cyc = 0, seed = 32'h27400B80;
  always #2.5 clk_sys_in = ~clk_sys_in;
  bcx_exec u_bcx_exec (.hready_in(hreadyout_out), .*);
  bcx_core_model #(.Z_VALUE(Z_VAL)) u_bcx_core_model (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .stack_push_in(stack_push_out), .stack_pop_in(stack_pop_out),
    .stack_data_in(stack_data_out), .z_ptr_out(z_ptr_in), .stack_top_out(stack_top_in));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare flags: borrow from 9-bit and 5-bit sums, carry-in only for cpc
  function automatic logic [7:0] cmpf(input logic [7:0] a, b, s, input logic c, zk);
    logic [7:0] q;
    logic       v;
    q = a - b - {7'h0, c};
    v = (a[7] != b[7]) && (q[7] != a[7]);
    return {s[7:6], {1'b0, a[3:0]} < {1'b0, b[3:0]} + {4'h0, c}, q[7] ^ v, v, q[7],
            (q == 8'h00) & zk, {1'b0, a} < {1'b0, b} + {8'h0, c}};
  endfunction
  // single aligned word; hready sampled at rising edges, no cycle count assumed
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    instr_valid_in <= 1'b0;
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h0, a};
    hwrite_in <= wr;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    rdv = hrdata_out;
    chk("hresp", 32'h0, {31'h0, hresp_out});
  endtask
  // word held until taken; valid left high so the next word can follow at once
  task automatic op(input logic [15:0] wd, input logic [15:0] npc, input logic [7:0] ns);
    instr_valid_in <= 1'b1;
    instr_word_in <= wd;
    do @(posedge clk_sys_in); while (instr_ready_out !== 1'b1);
    exp_q.push_back({ns, npc});
    pc_e = npc;
    sr_e = ns;
  endtask
  // result watcher: one note per taken word
  always @(posedge clk_sys_in) begin
    took <= instr_valid_in & instr_ready_out & !sys_rst_in;
    if (took && exp_q.size() > 0) begin
      chk("pc", {16'h0, exp_q[0][15:0]}, {16'h0, pc_out});
      chk("status_register", {24'h0, exp_q[0][23:16]}, {24'h0, status_register_out});
      void'(exp_q.pop_front());
    end
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    pc_e = 16'h0;
    sr_e = 8'h0;
    ahb(1'b0, `BCX_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rdv);
    ahb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rdv);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      d = r[7:0];
      e = (i % 4 == 0) ? d : r[15:8];
      ahb(1'b1, `BCX_ADDR_STATUS_REGISTER, {24'h0, r[23:16]});
      rd_data_in <= d;
      rr_data_in <= e;
      w = {6'h0, r[31:22]};
      case (i % 3)
        0: op(`BCX_OP_CP | w, pc_e + 16'h1, cmpf(d, e, r[23:16], 1'b0, 1'b1));
        1: op(`BCX_OP_CPC | w, pc_e + 16'h1, cmpf(d, e, r[23:16], r[16], r[17]));
        default: op(`BCX_OP_CPI | {4'h0, e[7:4], r[27:24], e[3:0]}, pc_e + 16'h1,
                    cmpf(d, e, r[23:16], 1'b0, 1'b1));
      endcase
    end
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      ahb(1'b1, `BCX_ADDR_STATUS_REGISTER, {24'h0, r[7:0]});
      w = (i[4] ? `BCX_OP_BRANCH_STATUS_CLEAR : `BCX_OP_BRANCH_STATUS_SET) | {6'h0, r[15:9], i[2:0]};
      k = {{9{r[15]}}, r[15:9]};
      op(w, (r[i[2:0]] != i[4]) ? pc_e + k + 16'h1 : pc_e + 16'h1, r[7:0]);
    end
    for (int i = 0; i < 30; i++) begin
      r = $random(seed);
      d = r[7:0];
      e = r[17] ? d : r[15:8];
      rd_data_in <= d;
      rr_data_in <= e;
      io_data_in <= e;
      next_two_word_in <= r[16];
      w = sop[i % 5] | {8'h0, r[31:28], 1'b0, r[26:24]};
      t = (i % 5 == 0) ? d == e : e[r[26:24]] == w[9];
      op(w, pc_e + (t ? (r[16] ? `BCX_SKIP2_WORDS : `BCX_SKIP1_WORDS) : 16'h1), sr_e);
    end
    ra = pc_e + 16'h1;
    op(`BCX_OP_INDIRECT_CALL, Z_VAL, sr_e);
    op(`BCX_OP_RET, ra, sr_e);
    ra = pc_e + 16'h1;
    op(`BCX_OP_INDIRECT_CALL, Z_VAL, sr_e);
    op(`BCX_OP_INTERRUPT_EXIT, ra, sr_e | 8'h80);
    ahb(1'b0, `BCX_ADDR_PC, 32'h0);
    chk("pc reg", {16'h0, pc_e}, rdv);
    // foreign opcode steps past and sets the sticky flag
    op(16'h0000, pc_e + 16'h1, sr_e);
    ahb(1'b0, `BCX_ADDR_STAT, 32'h0);
    chk("stat unhandled", 32'h2, rdv);
    ahb(1'b1, `BCX_ADDR_STAT, 32'h2);
    ahb(1'b0, `BCX_ADDR_STAT, 32'h0);
    chk("stat cleared", 32'h0, rdv);
    repeat (4) @(posedge clk_sys_in);
    chk("notes left", 32'h0, exp_q.size());
    complete_run();
  end
endmodule
